// ---- rtl/qrb_top.sv ----
// four-beat burst sram link: split data ports, shared address, echo and valid
//
// Functional notes
// - read and write addresses share one bus on alternating rising edges
// - each address moves a burst of four data words
// - beat width is 8, 9, 18 or 36 bits, four beats per location
// - both data ports move one beat on every true and complementary edge
// - only rising edges of both input clocks are used
// - with the bypass pin high, read data follows after two cycles
// - with the bypass pin low, read data follows after one cycle
// - read and write ports run independently and concurrently
// - each port has its own select
// - every synchronous input is registered before use
// - read data leaves from output registers
// - writes complete internally with no extra strobe
// - echo clocks go out beside the read data
// - valid flag is high while read burst data is driven
// - reads return the newest written data
`timescale 1ns/1ps
`include "qrb_map.svh"
module qrb_top #(
  parameter int W = 36,
  parameter int BW = 4,
  parameter int AW = 10
) (
  // system side
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // link clocks, true and complementary
  input wire logic K_CLK_I,
  input wire logic KN_CLK_I,
  // link control
  input wire logic [AW-1:0] ADDR_I,
  input wire logic READ_PORT_SELECT_N_I,
  input wire logic WRITE_PORT_SELECT_N_I,
  input wire logic PLL_BYPASS_N_I,
  // write data
  input wire logic [W-1:0] D_I,
  input wire logic [BW-1:0] BYTE_WRITE_SELECT_N_I,
  // read data and timing
  output logic [W-1:0] Q_O,
  output logic ECHO_TIMING_OUT_O,
  output logic ECHO_TIMING_OUT_N_O,
  output logic READ_VALID_FLAG_O,
  // system status
  output logic LONG_LATENCY_O,
  output logic WRITE_DONE_O,
  output logic READ_DONE_O
);
  import qrb_pkg::*;

  localparam int IW = AW + 1;
  localparam int LAT_L = `QRB_RD_LAT_LONG;
  localparam int LAT_S = `QRB_RD_LAT_SHORT;
  localparam int TB = `QRB_TOG_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // resets

  logic sys_rst_n;
  logic k_rst_n;

  qrb_sync #(.W(1)) u_sys_rst (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RSTN_I),
    .d_i(1'h1),
    .q_o(sys_rst_n)
  );

  // link side gets its own release so the first K edge is clean
  qrb_sync #(.W(1)) u_k_rst (
    .clk_i(K_CLK_I),
    .rst_n_i(RSTN_I),
    .d_i(1'h1),
    .q_o(k_rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // input registers

  logic [AW-1:0] addr_in_r;
  logic rps_in_n_r;
  logic wps_in_n_r;
  qrb_phase_type ph_r;
  qrb_phase_type ph_in_r;
  logic [W-1:0] d_k_r;
  logic [BW-1:0] bw_k_r;
  logic [W-1:0] d_kn_r;
  logic [BW-1:0] bw_kn_r;
  logic lat_long;

  // true edge: address, selects and the odd beats
  always_ff @(posedge K_CLK_I or negedge k_rst_n) begin
    if (!k_rst_n) begin
      addr_in_r <= '0;
      rps_in_n_r <= 1'h1;
      wps_in_n_r <= 1'h1;
      ph_r <= QRB_PH_READ;
      ph_in_r <= QRB_PH_READ;
      d_k_r <= '0;
      bw_k_r <= '1;
    end else begin
      addr_in_r <= ADDR_I;
      rps_in_n_r <= READ_PORT_SELECT_N_I;
      wps_in_n_r <= WRITE_PORT_SELECT_N_I;
      ph_in_r <= ph_r;
      ph_r <= (ph_r == QRB_PH_READ) ? QRB_PH_WRITE : QRB_PH_READ;
      d_k_r <= D_I;
      bw_k_r <= BYTE_WRITE_SELECT_N_I;
    end
  end

  // complementary edge: the even beats
  always_ff @(posedge KN_CLK_I or negedge k_rst_n) begin
    if (!k_rst_n) begin
      d_kn_r <= '0;
      bw_kn_r <= '1;
    end else begin
      d_kn_r <= D_I;
      bw_kn_r <= BYTE_WRITE_SELECT_N_I;
    end
  end

  // the bypass pin is static in use, so a plain level crossing does
  qrb_sync #(.W(1)) u_lat_sync (
    .clk_i(K_CLK_I),
    .rst_n_i(k_rst_n),
    .d_i(PLL_BYPASS_N_I),
    .q_o(lat_long)
  );

  ////////////////////////////////////////////////////////////////////////////
  // slot decode

  logic rd_go;
  logic wr_go;

  assign rd_go = (ph_in_r == QRB_PH_READ) && !rps_in_n_r;
  assign wr_go = (ph_in_r == QRB_PH_WRITE) && !wps_in_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // write path

  logic wr_h0_r;
  logic wr_h1_r;
  logic [AW-1:0] wr_addr_r;
  logic [W-1:0] kn_hold_r;
  logic [BW-1:0] bwn_hold_r;
  logic mem_we;
  logic [IW-1:0] mem_widx;
  logic [2*W-1:0] mem_wdata;
  logic [2*BW-1:0] mem_wmask_n;

  always_ff @(posedge K_CLK_I or negedge k_rst_n) begin
    if (!k_rst_n) begin
      wr_h0_r <= 1'h0;
      wr_h1_r <= 1'h0;
      wr_addr_r <= '0;
      kn_hold_r <= '0;
      bwn_hold_r <= '1;
    end else begin
      wr_h0_r <= wr_go;
      wr_h1_r <= wr_h0_r;
      kn_hold_r <= d_kn_r;
      bwn_hold_r <= bw_kn_r;
      if (wr_go) begin
        wr_addr_r <= addr_in_r;
      end
    end
  end

  // two beats per half burst, the even beat in the low lanes
  assign mem_we = wr_h0_r || wr_h1_r;
  assign mem_widx = {wr_addr_r, wr_h1_r ? `QRB_HALF_HI : `QRB_HALF_LO};
  assign mem_wdata = {d_k_r, kn_hold_r};
  assign mem_wmask_n = {bw_k_r, bwn_hold_r};

  ////////////////////////////////////////////////////////////////////////////
  // read path

  qrb_rd_state_type rd_state_r;
  qrb_rd_state_type rd_state_nxt;
  logic [AW-1:0] rd_addr_r;
  logic rd_launch;
  logic rd_drive;
  logic [AW-1:0] rd_launch_addr;
  logic [IW-1:0] mem_ridx;
  logic [2*W-1:0] mem_rdata;

  // the short mode launches straight off the decoded slot
  assign rd_launch = lat_long ? (rd_state_r == QRB_RD_WAIT) : rd_go;
  assign rd_launch_addr = lat_long ? rd_addr_r : addr_in_r;
  assign rd_drive = rd_launch || (rd_state_r == QRB_RD_HALF1);
  assign mem_ridx = (rd_state_r == QRB_RD_HALF1) ? {rd_addr_r, `QRB_HALF_HI} :
                                                   {rd_launch_addr, `QRB_HALF_LO};

  // switching the bypass pin mid-burst may cut that burst short
  always_comb begin
    case (rd_state_r)
      QRB_RD_IDLE: begin
        rd_state_nxt = !rd_go ? QRB_RD_IDLE : (lat_long ? QRB_RD_WAIT : QRB_RD_HALF1);
      end
      QRB_RD_WAIT: begin
        rd_state_nxt = QRB_RD_HALF1;
      end
      QRB_RD_HALF1: begin
        rd_state_nxt = !rd_go ? QRB_RD_IDLE : (lat_long ? QRB_RD_WAIT : QRB_RD_HALF1);
      end
      default: begin
        rd_state_nxt = QRB_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge K_CLK_I or negedge k_rst_n) begin
    if (!k_rst_n) begin
      rd_state_r <= QRB_RD_IDLE;
      rd_addr_r <= '0;
    end else begin
      rd_state_r <= rd_state_nxt;
      if (rd_go) begin
        rd_addr_r <= addr_in_r;
      end
    end
  end

  qrb_mem #(.W(W), .BW(BW), .IW(IW)) u_mem (
    .clk_i(K_CLK_I),
    .rst_n_i(k_rst_n),
    .we_i(mem_we),
    .widx_i(mem_widx),
    .wdata_i(mem_wdata),
    .wmask_n_i(mem_wmask_n),
    .ridx_i(mem_ridx),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output registers and echo

  logic [W-1:0] q_even_r;
  logic [W-1:0] q_odd_r;
  logic [W-1:0] q_kn_r;
  logic valid_r;

  always_ff @(posedge K_CLK_I or negedge k_rst_n) begin
    if (!k_rst_n) begin
      q_even_r <= '0;
      q_odd_r <= '0;
      valid_r <= 1'h0;
    end else begin
      valid_r <= rd_drive;
      if (rd_drive) begin
        q_even_r <= mem_rdata[W-1:0];
        q_odd_r <= mem_rdata[2*W-1:W];
      end
    end
  end

  // odd beat relaunched from the complementary edge
  always_ff @(posedge KN_CLK_I or negedge k_rst_n) begin
    if (!k_rst_n) begin
      q_kn_r <= '0;
    end else begin
      q_kn_r <= q_odd_r;
    end
  end

  // ddr output select; each register updates on the same edge that selects it
  assign Q_O = K_CLK_I ? q_even_r : q_kn_r;
  assign ECHO_TIMING_OUT_O = K_CLK_I;
  assign ECHO_TIMING_OUT_N_O = KN_CLK_I;
  assign READ_VALID_FLAG_O = valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // status crossing to the system clock

  logic wr_tog_r;
  logic rd_tog_r;
  logic [TB-1:0] tog_s;
  logic [TB-1:0] tog_d_r;
  logic wr_done_r;
  logic rd_done_r;

  always_ff @(posedge K_CLK_I or negedge k_rst_n) begin
    if (!k_rst_n) begin
      wr_tog_r <= 1'h0;
      rd_tog_r <= 1'h0;
    end else begin
      wr_tog_r <= wr_tog_r ^ wr_h1_r;
      rd_tog_r <= rd_tog_r ^ rd_launch;
    end
  end

  // toggles survive the clock ratio; pulses would not
  qrb_sync #(.W(TB)) u_stat_sync (
    .clk_i(CLK_SYS_I),
    .rst_n_i(sys_rst_n),
    .d_i({lat_long, rd_tog_r, wr_tog_r}),
    .q_o(tog_s)
  );

  always_ff @(posedge CLK_SYS_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      tog_d_r <= '0;
      wr_done_r <= 1'h0;
      rd_done_r <= 1'h0;
    end else begin
      tog_d_r <= tog_s;
      wr_done_r <= tog_s[0] ^ tog_d_r[0];
      rd_done_r <= tog_s[1] ^ tog_d_r[1];
    end
  end

  assign WRITE_DONE_O = wr_done_r;
  assign READ_DONE_O = rd_done_r;
  assign LONG_LATENCY_O = tog_d_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_rd_alt;
    @(posedge K_CLK_I) disable iff (!k_rst_n)
      rd_go |=> !rd_go ##1 ($past(ph_in_r) == QRB_PH_WRITE);
  endproperty
  a_rd_alt: assert property (p_rd_alt) else $error("read slots not alternating");

  property p_burst_halves;
    @(posedge K_CLK_I) disable iff (!k_rst_n)
      wr_h0_r |-> (mem_widx[0] == `QRB_HALF_LO) ##1 (wr_h1_r && mem_widx[0] == `QRB_HALF_HI);
  endproperty
  a_burst_halves: assert property (p_burst_halves) else $error("burst halves out of order");

  property p_rd_lat_long;
    @(posedge K_CLK_I) disable iff (!k_rst_n)
      (rd_go && lat_long) |-> ##LAT_L valid_r ##1 valid_r;
  endproperty
  a_rd_lat_long: assert property (p_rd_lat_long) else $error("long read latency wrong");

  property p_rd_lat_short;
    @(posedge K_CLK_I) disable iff (!k_rst_n)
      (rd_go && !lat_long) |-> ##LAT_S (valid_r && rd_state_r == QRB_RD_HALF1) ##1 valid_r;
  endproperty
  a_rd_lat_short: assert property (p_rd_lat_short) else $error("short read latency wrong");

  property p_concurrent;
    @(posedge K_CLK_I) disable iff (!k_rst_n)
      (rd_go && mem_we) |-> ##2 valid_r;
  endproperty
  a_concurrent: assert property (p_concurrent) else $error("read stalled by write");

  property p_wr_deselect;
    @(posedge K_CLK_I) disable iff (!k_rst_n)
      (ph_in_r == QRB_PH_WRITE && wps_in_n_r) |=> !wr_h0_r ##1 !wr_h1_r;
  endproperty
  a_wr_deselect: assert property (p_wr_deselect) else $error("deselected write ran");

  property p_in_reg;
    @(posedge K_CLK_I) disable iff (!k_rst_n)
      wr_h0_r |-> ($past(WRITE_PORT_SELECT_N_I, 2) == 1'h0);
  endproperty
  a_in_reg: assert property (p_in_reg) else $error("write without registered select");

  property p_self_timed;
    @(posedge K_CLK_I) disable iff (!k_rst_n)
      wr_go |=> mem_we [*2];
  endproperty
  a_self_timed: assert property (p_self_timed) else $error("write not completed");

  property p_valid_half;
    @(posedge K_CLK_I) disable iff (!k_rst_n)
      $rose(valid_r) |=> valid_r;
  endproperty
  a_valid_half: assert property (p_valid_half) else $error("valid shorter than burst");

endmodule : qrb_top

// ---- rtl/qrb_map.svh ----
// constants of the four-beat burst sram link
`ifndef QRB_MAP_SVH
`define QRB_MAP_SVH
`define QRB_BURST_LEN 4
`define QRB_HALF_LO 1'h0
`define QRB_HALF_HI 1'h1
`define QRB_RD_LAT_LONG 2
`define QRB_RD_LAT_SHORT 1
`define QRB_TOG_BITS 3
`endif

// ---- rtl/qrb_pkg.sv ----
// types of the four-beat burst sram link
package qrb_pkg;

  typedef enum logic [2:0] {
    QRB_RD_IDLE = 3'h1,
    QRB_RD_WAIT = 3'h2,
    QRB_RD_HALF1 = 3'h4
  } qrb_rd_state_type;

  typedef enum logic [0:0] {
    QRB_PH_READ = 1'h0,
    QRB_PH_WRITE = 1'h1
  } qrb_phase_type;

endpackage : qrb_pkg

// ---- rtl/qrb_sync.sv ----
// two-flop synchroniser with asynchronous clear
`timescale 1ns/1ps
module qrb_sync #(
  parameter int W = 1
) (
  // clock and clear
  input wire logic clk_i,
  input wire logic rst_n_i,
  // crossing data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  // meta_r is read by hold_r alone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= d_i;
      hold_r <= meta_r;
    end
  end

  assign q_o = hold_r;

endmodule : qrb_sync

// ---- rtl/qrb_mem.sv ----
// burst array in half-burst words with lane masks and write bypass
`timescale 1ns/1ps
module qrb_mem #(
  parameter int W = 36,
  parameter int BW = 4,
  parameter int IW = 11
) (
  // clock and clear
  input wire logic clk_i,
  input wire logic rst_n_i,
  // write side, one half burst
  input wire logic we_i,
  input wire logic [IW-1:0] widx_i,
  input wire logic [2*W-1:0] wdata_i,
  input wire logic [2*BW-1:0] wmask_n_i,
  // read side
  input wire logic [IW-1:0] ridx_i,
  output logic [2*W-1:0] rdata_o
);

  localparam int LW = W / BW;

  logic [2*W-1:0] mem_r [0:(1<<IW)-1];
  logic [2*W-1:0] merged;
  logic hit;

  function automatic logic [2*W-1:0] lane_merge(input logic [2*W-1:0] old_d,
                                                input logic [2*W-1:0] new_d,
                                                input logic [2*BW-1:0] mask_n);
    logic [2*W-1:0] res;
    res = old_d;
    for (int i = 0; i < 2*BW; i++) begin
      if (!mask_n[i]) begin
        res[i*LW +: LW] = new_d[i*LW +: LW];
      end
    end
    return res;
  endfunction : lane_merge

  assign merged = lane_merge(mem_r[widx_i], wdata_i, wmask_n_i);
  // a read meeting the committing write sees the new lanes
  assign hit = we_i && (ridx_i == widx_i);
  assign rdata_o = hit ? merged : mem_r[ridx_i];

  // no strobe: the commit is the write itself
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[widx_i] <= merged;
    end
  end

  property p_bypass;
    @(posedge clk_i) disable iff (!rst_n_i)
      (we_i && ridx_i == widx_i && wmask_n_i == '0) |-> rdata_o == wdata_i;
  endproperty
  a_bypass: assert property (p_bypass) else $error("read missed committing write");

  property p_stored;
    @(posedge clk_i) disable iff (!rst_n_i)
      we_i ##1 (!we_i && ridx_i == $past(widx_i)) |-> rdata_o == $past(merged);
  endproperty
  a_stored: assert property (p_stored) else $error("write not stored");

endmodule : qrb_mem

// ---- sim/qrb_ctrl_model.sv ----
// controller-side model: link clocks, slotted requests, echo-clocked read capture
`timescale 1ns/1ps
module qrb_ctrl_model #(
  parameter int W = 36,
  parameter int BW = 4,
  parameter int AW = 10
) (
  // reset as the device sees it
  input wire logic rst_n_i,
  // link outputs
  output logic k_o,
  output logic kn_o,
  output logic [AW-1:0] addr_o,
  output logic rps_n_o,
  output logic wps_n_o,
  output logic [W-1:0] d_o,
  output logic [BW-1:0] bws_n_o,
  // read return
  input wire logic [W-1:0] q_i,
  input wire logic echo_i,
  input wire logic echo_n_i,
  input wire logic valid_i
);
  bit rq_en[$];
  bit wq_en[$];
  logic [AW-1:0] rq_a[$];
  logic [AW-1:0] wq_a[$];
  logic [4*W-1:0] wq_d[$];
  logic [4*BW-1:0] wq_m[$];
  logic [W-1:0] dq[$];
  logic [BW-1:0] mq[$];
  int iss_q[$];
  bit pend, w_en, rs;
  logic [AW-1:0] w_a;
  logic [4*W-1:0] w_d, cap_word;
  logic [4*BW-1:0] w_m;
  int cnt, cap_lat, nbeat, vcnt;
  event got;

  task automatic push(input bit rd, input logic [AW-1:0] ra, input bit wr, input logic [AW-1:0] wa,
                      input logic [4*W-1:0] d, input logic [4*BW-1:0] m);
    rq_en.push_back(rd);
    rq_a.push_back(ra);
    wq_en.push_back(wr);
    wq_a.push_back(wa);
    wq_d.push_back(d);
    wq_m.push_back(m);
  endtask : push

  // idle lines show the inverse of the last value, never a stale copy
  task automatic next_beat();
    if (dq.size() > 0) begin
      d_o = dq.pop_front();
      bws_n_o = mq.pop_front();
    end else begin
      d_o = ~d_o;
      bws_n_o = ~bws_n_o;
    end
  endtask : next_beat

  ////////////////////////////////////////////////////////////////
  // 32 ns period stays well under the link's top rate
  initial begin
    k_o = 1'b0;
    kn_o = 1'b1;
    addr_o = '0;
    rps_n_o = 1'b1;
    wps_n_o = 1'b1;
    d_o = '0;
    bws_n_o = '1;
    #7;
    forever begin
      k_o = 1'b1;
      kn_o = 1'b0;
      #16;
      k_o = 1'b0;
      kn_o = 1'b1;
      #16;
    end
  end

  always @(posedge k_o) begin
    cnt = rst_n_i ? cnt + 1 : 0;
    #1;
    if (!wps_n_o && !rs) begin
      for (int i = 0; i < 4; i++) begin
        dq.push_back(w_d[i*W +: W]);
        mq.push_back(w_m[i*BW +: BW]);
      end
    end
    if (!rps_n_o && rs) iss_q.push_back(cnt);
    next_beat();
    rps_n_o = 1'b1;
    wps_n_o = 1'b1;
    addr_o = ~addr_o;
    rs = 1'b0;
    // third rise after release is a read slot, slots alternate
    if (cnt >= 2 && cnt % 2 == 0 && rq_en.size() > 0) begin
      w_en = wq_en.pop_front();
      w_a = wq_a.pop_front();
      w_d = wq_d.pop_front();
      w_m = wq_m.pop_front();
      addr_o = rq_a.pop_front();
      rps_n_o = !rq_en.pop_front();
      // wrong-slot select: the device must ignore it
      wps_n_o = !w_en;
      rs = 1'b1;
      pend = 1'b1;
    end else if (pend) begin
      pend = 1'b0;
      addr_o = w_a;
      wps_n_o = !w_en;
      // wrong-slot select: the device must ignore it
      rps_n_o = !w_en;
    end
  end

  always @(posedge kn_o) begin
    #1;
    next_beat();
  end

  ////////////////////////////////////////////////////////////////
  // capture mid-beat off the echoes, qualified by the valid flag
  always @(posedge echo_i) begin
    #8;
    if (valid_i === 1'b1) begin
      vcnt++;
      if (nbeat == 0) cap_lat = cnt - iss_q.pop_front();
      cap_word[nbeat*W +: W] = q_i;
      nbeat++;
    end
  end

  always @(posedge echo_n_i) begin
    #8;
    if (valid_i === 1'b1) begin
      cap_word[nbeat*W +: W] = q_i;
      nbeat++;
      if (nbeat >= 4) begin
        nbeat = 0;
        ->got;
      end
    end
  end
endmodule : qrb_ctrl_model

// ---- sim/qrb_top_tb_top.sv ----
// self-checking bench for the four-beat burst sram link
`timescale 1ns/1ps
module qrb_top_tb_top;
  localparam int W = 36;
  localparam int BW = 4;
  localparam int AW = 10;
  logic CLK_SYS_I, RSTN_I, PLL_BYPASS_N_I, K_CLK_I, KN_CLK_I;
  logic READ_PORT_SELECT_N_I, WRITE_PORT_SELECT_N_I;
  logic [AW-1:0] ADDR_I;
  logic [W-1:0] D_I, Q_O;
  logic [BW-1:0] BYTE_WRITE_SELECT_N_I;
  logic ECHO_TIMING_OUT_O, ECHO_TIMING_OUT_N_O, READ_VALID_FLAG_O;
  logic LONG_LATENCY_O, WRITE_DONE_O, READ_DONE_O;
  int err_count, n_tests, n_wr, n_rd, wdone, rdone;
  integer seed = 32'hDC8A6681;
  logic [31:0] r;
  logic [4*W-1:0] mem [logic [AW-1:0]];
  logic [4*W-1:0] exp_q[$];
  int lat_q[$];

  qrb_top #(.W(W), .BW(BW), .AW(AW)) qrb_top_inst (
    .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .K_CLK_I(K_CLK_I), .KN_CLK_I(KN_CLK_I),
    .ADDR_I(ADDR_I), .READ_PORT_SELECT_N_I(READ_PORT_SELECT_N_I),
    .WRITE_PORT_SELECT_N_I(WRITE_PORT_SELECT_N_I), .PLL_BYPASS_N_I(PLL_BYPASS_N_I),
    .D_I(D_I), .BYTE_WRITE_SELECT_N_I(BYTE_WRITE_SELECT_N_I), .Q_O(Q_O),
    .ECHO_TIMING_OUT_O(ECHO_TIMING_OUT_O), .ECHO_TIMING_OUT_N_O(ECHO_TIMING_OUT_N_O),
    .READ_VALID_FLAG_O(READ_VALID_FLAG_O), .LONG_LATENCY_O(LONG_LATENCY_O),
    .WRITE_DONE_O(WRITE_DONE_O), .READ_DONE_O(READ_DONE_O));

  qrb_ctrl_model #(.W(W), .BW(BW), .AW(AW)) qrb_ctrl_model_inst (
    .rst_n_i(RSTN_I), .k_o(K_CLK_I), .kn_o(KN_CLK_I), .addr_o(ADDR_I),
    .rps_n_o(READ_PORT_SELECT_N_I), .wps_n_o(WRITE_PORT_SELECT_N_I), .d_o(D_I),
    .bws_n_o(BYTE_WRITE_SELECT_N_I), .q_i(Q_O), .echo_i(ECHO_TIMING_OUT_O),
    .echo_n_i(ECHO_TIMING_OUT_N_O), .valid_i(READ_VALID_FLAG_O));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [4*W-1:0] seen, input logic [4*W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  function automatic logic [4*W-1:0] rnd_d();
    logic [159:0] v;
    v = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    return v[4*W-1:0];
  endfunction : rnd_d

  // reference array: low mask bit writes that lane of that beat
  task automatic pair(input bit rd, input logic [AW-1:0] ra, input bit wr, input logic [AW-1:0] wa,
                      input logic [4*W-1:0] d, input logic [4*BW-1:0] m);
    if (rd) begin
      exp_q.push_back(mem[ra]);
      lat_q.push_back(PLL_BYPASS_N_I ? 2 : 1);
      n_rd++;
    end
    if (wr) begin
      n_wr++;
      for (int i = 0; i < 4*W; i++) if (!m[(i/W)*BW + (i%W)/(W/BW)]) mem[wa][i] = d[i];
    end
    qrb_ctrl_model_inst.push(rd, ra, wr, wa, d, m);
  endtask : pair

  task automatic wait_idle();
    for (int i = 0; i < 3000 && (exp_q.size() > 0 || qrb_ctrl_model_inst.rq_en.size() > 0); i++) begin
      @(posedge CLK_SYS_I);
    end
    repeat (20) @(posedge CLK_SYS_I);
    chk("drained", exp_q.size(), 0);
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////
  always #10 CLK_SYS_I = ~CLK_SYS_I;

  always @(qrb_ctrl_model_inst.got) begin
    chk("rdata", qrb_ctrl_model_inst.cap_word, exp_q.pop_front());
    chk("latency", qrb_ctrl_model_inst.cap_lat, lat_q.pop_front());
  end

  // sampled mid-cycle, away from the edge that launches the pulses
  always @(negedge CLK_SYS_I) begin
    if (WRITE_DONE_O === 1'b1) wdone++;
    if (READ_DONE_O === 1'b1) rdone++;
  end

  always @(negedge CLK_SYS_I) begin
    if (RSTN_I === 1'b1) begin
      chk("echo", ECHO_TIMING_OUT_O, K_CLK_I);
      chk("echo_n", ECHO_TIMING_OUT_N_O, KN_CLK_I);
    end
  end

  // generous span: the whole sequence needs well under a fifth of it
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end

  initial begin
    CLK_SYS_I = 1'b0;
    RSTN_I = 1'b0;
    PLL_BYPASS_N_I = 1'b1;
    repeat (6) @(posedge CLK_SYS_I);
    chk("valid_in_reset", READ_VALID_FLAG_O, 1'b0);
    #1 RSTN_I = 1'b1;
    for (int a = 0; a < 8; a++) pair(1'b0, '0, 1'b1, a, rnd_d(), '0);
    for (int md = 1; md >= 0; md--) begin
      wait_idle();
      @(posedge CLK_SYS_I);
      #1 PLL_BYPASS_N_I = (md == 1);
      repeat (40) @(posedge CLK_SYS_I);
      chk("long_latency", LONG_LATENCY_O, md == 1);
      pair(1'b0, '0, 1'b1, 10'h5, rnd_d(), '0);
      pair(1'b1, 10'h5, 1'b1, 10'h5, rnd_d(), 16'h5A5A);
      pair(1'b1, 10'h5, 1'b0, '0, rnd_d(), '0);
      repeat (24) begin
        r = $random(seed);
        pair(r[0], r[3:1], r[4], r[7:5], rnd_d(), r[31:16]);
      end
    end
    wait_idle();
    chk("write_done", wdone, n_wr);
    chk("read_done", rdone, n_rd);
    chk("valid_cycles", qrb_ctrl_model_inst.vcnt, 2*n_rd);
    end_of_test();
  end
endmodule : qrb_top_tb_top
